// [arr_defines.svh]
// Register offsets, field layout and reset values for the ADC result bank
`ifndef ARR_DEFINES_SVH
`define ARR_DEFINES_SVH
`define ARR_CMD_DIE_TEMP 8'h05
`define ARR_CMD_MOD_CUR 8'h06
`define ARR_CMD_SRC_MON 8'h07
`define ARR_CODE_MSB 9
`define ARR_RSVD_LSB 10
`define ARR_RESULT_RESET 10'h000
`define ARR_TEMP_OFFSET_K 273
`define ARR_CODE_FULL_SCALE 1024
`endif

// [arr_pkg.sv]
// Types shared by the ADC result bank
package arr_pkg;
  typedef logic [9:0] arr_code_type;
  typedef enum logic [1:0] {
    ARR_SRC_TEMP = 2'b00,
    ARR_SRC_MOD = 2'b01,
    ARR_SRC_SOURCE = 2'b10,
    ARR_SRC_MONITOR = 2'b11
  } arr_src_type;
  typedef struct packed {
    logic valid;
    arr_src_type src;
    arr_code_type code;
  } arr_conv_type;
  typedef struct packed {
    logic rd;
    logic [7:0] cmd;
  } arr_req_type;
endpackage : arr_pkg

// [arr_result_slot.sv]
// One stored ADC result field with zeroed reserved bits
`timescale 1ns/100ps
module arr_result_slot #(
  parameter int CODE_W = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [CODE_W-1:0] code_in,
  output logic [15:0] word
);
  if (CODE_W < 1 || CODE_W > 16) begin : g_bad_code_w
    $error("arr_result_slot: CODE_W out of range");
  end

  logic [CODE_W-1:0] code;

  always_ff @(posedge clk) begin
    if (rst) begin
      code <= '0; // R7
    end else if (load) begin
      code <= code_in;
    end
  end

  // Reserved upper bits are hard zero
  assign word = {{(16-CODE_W){1'b0}}, code}; // R7
endmodule : arr_result_slot

// [arr_result_regs.sv]
// Read-back register bank for die temperature and current ADC results
//
// Contract
// R1: Command 0x05 returns the die temperature code in 9:0, 15:10 reserved.
// R2: The temperature code weighs 0.5 C per count with a 273 C offset.
// R3: Command 0x06 returns the average modulation current code in 9:0.
// R4: Modulation current is code/1024 times (range+1) times 9 mA nominal.
// R5: With the mode bit clear, 0x07 holds the source pin current code.
// R6: With the mode bit set, 0x07 holds the log-scale monitor diode code.
// R7: Results read zero until first converted; reserved bits read zero.
`timescale 1ns/100ps
`include "arr_defines.svh"
module arr_result_regs #(
  parameter int CODE_W = 10
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire arr_pkg::arr_conv_type CONV,
  input wire logic POWER_CTRL_MODE,
  input wire arr_pkg::arr_req_type REQ,
  output logic [15:0] RDATA,
  output logic RVALID,
  output logic RHIT
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // The serial word is fixed at 16 bits, so the code field must leave
  // exactly the reserved bits above it
  if (CODE_W != `ARR_CODE_MSB + 1) begin : g_bad_code_w
    $error("arr_result_regs: CODE_W must match the result field");
  end
  if (`ARR_RSVD_LSB != `ARR_CODE_MSB + 1) begin : g_bad_layout
    $error("arr_result_regs: reserved bits must sit above the code");
  end
  if (`ARR_CMD_DIE_TEMP == `ARR_CMD_MOD_CUR ||
      `ARR_CMD_MOD_CUR == `ARR_CMD_SRC_MON ||
      `ARR_CMD_DIE_TEMP == `ARR_CMD_SRC_MON) begin : g_bad_map
    $error("arr_result_regs: command codes must differ");
  end

  // ------------------------------------------------------------
  // Result capture
  // ------------------------------------------------------------
  logic ld_temp;
  logic ld_mod;
  logic ld_shared;
  logic [15:0] temp_word;
  logic [15:0] mod_word;
  logic [15:0] shared_word;


  // A conversion is taken only on its valid pulse, and only by the slot
  // that owns its source
  function automatic logic conv_for(
    input arr_pkg::arr_conv_type conv,
    input arr_pkg::arr_src_type src
  );
    conv_for = conv.valid && conv.src == src;
  endfunction : conv_for

  // Temperature code is stored raw; 0.5 C/LSB scaling is software's job
  assign ld_temp = conv_for(CONV, arr_pkg::ARR_SRC_TEMP); // R1 R2
  // Modulation code is linear in range setting; stored raw
  assign ld_mod = conv_for(CONV, arr_pkg::ARR_SRC_MOD); // R3 R4
  // The shared slot only accepts the source that matches the mode, so a
  // conversion of the other kind arriving after a mode change is never stored.
  // It is not cleared on a mode change: the last accepted value stays
  // until a conversion of the new kind arrives.
  assign ld_shared = POWER_CTRL_MODE ?
    conv_for(CONV, arr_pkg::ARR_SRC_MONITOR) : // R6
    conv_for(CONV, arr_pkg::ARR_SRC_SOURCE); // R5

  arr_result_slot #(.CODE_W(CODE_W)) u_temp (
    .clk(CORE_CLK),
    .rst(RST),
    .load(ld_temp),
    .code_in(CONV.code),
    .word(temp_word)
  );
  arr_result_slot #(.CODE_W(CODE_W)) u_mod (
    .clk(CORE_CLK),
    .rst(RST),
    .load(ld_mod),
    .code_in(CONV.code),
    .word(mod_word)
  );
  arr_result_slot #(.CODE_W(CODE_W)) u_shared (
    .clk(CORE_CLK),
    .rst(RST),
    .load(ld_shared),
    .code_in(CONV.code),
    .word(shared_word)
  );

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // One-hot select: bit 0 temperature, bit 1 modulation, bit 2 shared
  function automatic logic [2:0] cmd_select(input logic [7:0] cmd);
    case (cmd)
      `ARR_CMD_DIE_TEMP: cmd_select = 3'h1; // R1
      `ARR_CMD_MOD_CUR: cmd_select = 3'h2; // R3
      `ARR_CMD_SRC_MON: cmd_select = 3'h4; // R5 R6
      default: cmd_select = 3'h0;
    endcase
  endfunction : cmd_select

  // Nothing selected reads zero, which also answers unmapped commands
  function automatic logic [15:0] read_word(
    input logic [2:0] sel,
    input logic [15:0] temp,
    input logic [15:0] mod,
    input logic [15:0] shared
  );
    case (sel)
      3'h1: read_word = temp;
      3'h2: read_word = mod;
      3'h4: read_word = shared;
      default: read_word = 16'h0000;
    endcase
  endfunction : read_word

  logic [2:0] rd_sel;

  assign rd_sel = REQ.rd ? cmd_select(REQ.cmd) : 3'h0;

  // ------------------------------------------------------------
  // Read strobe
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RVALID <= 1'b0;
    end else begin
      RVALID <= REQ.rd; // R1
    end
  end

  // ------------------------------------------------------------
  // Hit flag
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RHIT <= 1'b0;
    end else begin
      RHIT <= |rd_sel;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Held between reads so a slow host may take it late; a read in the
  // cycle of a conversion returns the value stored before it
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RDATA <= 16'h0000; // R7
    end else if (REQ.rd) begin
      RDATA <= read_word(rd_sel, temp_word, mod_word, shared_word);
    end
  end
endmodule : arr_result_regs

// [arr_result_regs_assertions.sv]
// Checker for the ADC result bank read port
`timescale 1ns/100ps
module arr_checker (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire arr_pkg::arr_req_type REQ,
  input wire logic [15:0] RDATA,
  input wire logic RVALID,
  input wire logic RHIT
);
  a_answer_next: assert property (
    @(posedge CORE_CLK) disable iff (RST) 1 |=> RVALID == $past(REQ.rd))
    else $error("read answer mistimed");
  a_hit_decode: assert property (
    @(posedge CORE_CLK) disable iff (RST) REQ.rd |=>
    RHIT == ($past(REQ.cmd) inside {8'h05, 8'h06, 8'h07}))
    else $error("hit flag wrong");
  a_rsvd_zero: assert property (
    @(posedge CORE_CLK) disable iff (RST) RDATA[15:10] == 6'h00)
    else $error("reserved bits set");
  a_hit_in_answer: assert property (
    @(posedge CORE_CLK) disable iff (RST) RHIT |-> RVALID)
    else $error("hit flag outside an answer");
  a_data_held: assert property (
    @(posedge CORE_CLK) disable iff (RST) !REQ.rd |=> $stable(RDATA))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (
    @(posedge CORE_CLK) disable iff (RST)
    REQ.rd && !(REQ.cmd inside {8'h05, 8'h06, 8'h07}) |=>
    RDATA == 16'h0000 && !RHIT)
    else $error("unmapped read not zero");
endmodule : arr_checker
bind arr_result_regs arr_checker chk (.CORE_CLK(CORE_CLK), .RST(RST),
  .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID), .RHIT(RHIT));

// [arr_host.sv]
// Host model issuing one-cycle read requests
`timescale 1ns/100ps
module arr_host (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] cmd,
  output arr_pkg::arr_req_type req = '0
);
  // Idle command toggles so a stale code is never mistaken for a read
  always_ff @(posedge clk) req <= {go, go ? cmd : ~req.cmd};
endmodule : arr_host

// [arr_result_regs_test.sv]
// Self-checking bench for the ADC result bank
`timescale 1ns/100ps
module arr_result_regs_test;
  logic clk = 0, rst = 1, mode = 0, go = 0, rvalid, rhit;
  logic [7:0] cmd = 8'h00;
  logic [15:0] rdata;
  logic [9:0] m [3] = '{3{10'h000}};
  logic [16:0] exp_q [$];
  arr_pkg::arr_conv_type conv = '0;
  arr_pkg::arr_req_type req;
  int miscompares = 0, comparisons = 0, cyc = 0;
  arr_host host (.clk(clk), .go(go), .cmd(cmd), .req(req));
  arr_result_regs dut (.CORE_CLK(clk), .RST(rst), .CONV(conv),
    .POWER_CTRL_MODE(mode), .REQ(req), .RDATA(rdata), .RVALID(rvalid),
    .RHIT(rhit));
  initial forever #5 clk = ~clk;
  task tally_and_finish;
    // An answer that never came counts against the run
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task check(input logic [16:0] e, input logic [16:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t %h %h", $time, e, g);
    end
  endtask : check
  always @(posedge clk) begin
    cyc++;
    if (rvalid !== 1'b0 && exp_q.size() > 0) begin
      check(exp_q.pop_front(), {rhit, rdata});
    end else if (rvalid !== 1'b0) begin
      check(17'h00000, {rvalid, 16'h0000});
    end
    if (cyc == 3000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  task put(input logic [1:0] s, input logic [9:0] c);
    @(posedge clk) conv <= {1'b1, s, c};
    if (s < 2) m[s] = c;
    else if (s[0] == mode) m[2] = c;
    @(posedge clk) conv.valid <= 1'b0;
  endtask : put
  task rd(input logic [7:0] c);
    @(posedge clk) go <= 1'b1;
    cmd <= c;
    // Unmapped codes answer zero with no hit
    exp_q.push_back(c inside {[8'h05:8'h07]} ?
      {7'h40, m[c[1:0] - 2'd1]} : 17'h00000);
  endtask : rd
  initial begin
    void'($urandom(99487));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (k > 0) begin
        @(posedge clk) mode <= k[1];
        for (int s = 0; s < 4; s++) put(s[1:0], 10'($urandom));
      end
      for (int c = 4; c < 9; c++) rd(c[7:0]);
      rd(8'($urandom));
      @(posedge clk) go <= 1'b0;
    end
    repeat (4) @(posedge clk);
    // Reset in mid-run must clear every stored result
    @(posedge clk) rst <= 1'b1;
    m = '{3{10'h000}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int c = 5; c < 8; c++) rd(c[7:0]);
    @(posedge clk) go <= 1'b0;
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule : arr_result_regs_test
